// ### verilog/phy_strap_config_and_control.sv
// Strap decoding, management register file and upper control bits of a 10/100 transceiver.
// Assumes a management frame engine on clk_sys presents decoded one-cycle requests.
`timescale 1ns/1ns
`include "phy_strap_map.svh"
module phy_strap_config_and_control
  import phy_strap_pkg::*;
(
  input  wire logic          clk_sys,
  input  wire logic          nrst,
  input  wire strap_bundle_t straps,
  input  wire logic          pwrdwn_pin,
  input  wire mgmt_req_t     mgmt_req,
  output logic               mgmt_ack,
  output logic [15:0]        mgmt_rdata,
  output logic [4:0]         phy_address,
  output logic               ready,
  output logic               loopback_en,
  output logic               speed_100,
  output logic               autoneg_en,
  output logic               full_duplex,
  output logic               powerdown,
  output logic               mii_isolate,
  output logic               line_tx_oe_n,
  output logic [4:0]         led_status,
  output logic [4:0]         led_out,
  output logic [4:0]         led_oe_n
);
  logic [12:0]   strap_meta;
  logic [12:0]   strap_sync;
  logic          pwr_meta;
  logic          pwr_sync;
  cfg_state_t    state;
  cfg_state_t    next_state;
  logic [7:0]    count;
  logic [7:0]    next_count;
  strap_bundle_t latched;
  strap_bundle_t next_latched;
  logic [15:0]   control;
  logic [15:0]   next_control;
  logic [15:0]   advert;
  logic [15:0]   next_advert;
  logic [15:0]   irq_en;
  logic [15:0]   next_irq_en;
  logic [15:0]   fast_ctl;
  logic [15:0]   next_fast_ctl;
  logic [15:0]   mode_ctl;
  logic [15:0]   next_mode_ctl;
  logic          next_ack;
  logic [15:0]   next_rdata;
  logic [4:0]    led_pol;
  logic [4:0]    next_led_pol;
  logic          hit;
  strap_bundle_t s;

  // Decodes the three advertisement straps into bits 8 to 5.
  function automatic logic [3:0] adv_decode(input logic a, input logic b, input logic d);
    case ({a, b, d})
      3'b111:  adv_decode = 4'hf;
      3'b100:  adv_decode = 4'h4;
      3'b101:  adv_decode = 4'hc;
      3'b010:  adv_decode = 4'h1;
      3'b011:  adv_decode = 4'h3;
      3'b110:  adv_decode = 4'h5;
      default: adv_decode = 4'hf;
    endcase
  endfunction : adv_decode

  // Builds the control and advertisement reset images from a strap snapshot.
  function automatic logic [31:0] strap_image(input strap_bundle_t t);
    logic [15:0] c;
    logic [15:0] v;
    c = `CTL_RESET_VALUE;
    v = `ADV_RESET_VALUE;
    c[`CTL_AUTONEG_POS] = t.multi_function_straps[0];
    // With the negotiation strap low, v keeps the ordinary advertisement default.
    if (t.multi_function_straps[0]) begin
      v[`ADV_FAST_FULL_POS:`ADV_SLOW_HALF_POS] =
        adv_decode(t.advertise_strap_a, t.advertise_strap_b, t.duplex_strap);
    end else begin
      c[`CTL_LOOPBACK_POS] = t.advertise_strap_b;
      c[`CTL_DUPLEX_POS]   = t.duplex_strap;
    end
    c[`CTL_ISOLATE_POS] = (t.address_straps == 5'h00);
    strap_image = {c, v};
  endfunction : strap_image

  // Straps and the power-down pin come from pins and are synchronised first.
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      strap_meta <= 13'h0000;
      strap_sync <= 13'h0000;
      pwr_meta   <= 1'b0;
      pwr_sync   <= 1'b0;
    end else begin
      strap_meta <= straps;
      strap_sync <= strap_meta;
      pwr_meta   <= pwrdwn_pin;
      pwr_sync   <= pwr_meta;
    end
  end

  assign s   = strap_bundle_t'(strap_sync);
  assign hit = mgmt_req.valid && (mgmt_req.phy_addr == latched.address_straps);

  always_comb begin
    next_state    = state;
    next_count    = count;
    next_latched  = latched;
    next_control  = control;
    next_advert   = advert;
    next_irq_en   = irq_en;
    next_fast_ctl = fast_ctl;
    next_mode_ctl = mode_ctl;
    next_led_pol  = led_pol;
    next_ack      = 1'b0;
    next_rdata    = mgmt_rdata;
    case (state)
      ST_HW_RESET: begin
        // Three cycles let the synchronisers fill before the straps are read.
        next_count = count + 8'd1;
        if (count == 8'd2) begin
          next_state = ST_LATCH;
        end
      end
      ST_LATCH: begin
        next_latched = s;
        next_led_pol = s.address_straps;
        {next_control, next_advert} = strap_image(s);
        next_state = ST_RUN;
      end
      ST_RUN: begin
        if (hit) begin
          next_ack = 1'b1;
          if (mgmt_req.write) begin
            case (mgmt_req.reg_addr)
              `REG_TRANSCEIVER_CONTROL: begin
                next_control = mgmt_req.wdata & 16'hfd80;
                if (mgmt_req.wdata[`CTL_SOFT_RESET_POS]) begin
                  next_state = ST_SOFT_RESET;
                  next_count = 8'd0;
                end
              end
              `REG_NEGOTIATION_ADVERTISEMENT: next_advert   = mgmt_req.wdata;
              `REG_IRQ_ENABLE:                next_irq_en   = mgmt_req.wdata;
              `REG_FAST_TX_CONTROL_STATUS:    next_fast_ctl = mgmt_req.wdata;
              `REG_TRANSCEIVER_MODE_CONTROL:  next_mode_ctl = mgmt_req.wdata;
              default: next_ack = 1'b1;
            endcase
          end else begin
            case (mgmt_req.reg_addr)
              `REG_TRANSCEIVER_CONTROL:       next_rdata = control;
              `REG_TRANSCEIVER_STATUS:        next_rdata = `STATUS_VALUE;
              `REG_PHY_IDENTIFIER_HIGH:       next_rdata = `ID_HIGH_VALUE;
              `REG_PHY_IDENTIFIER_LOW:        next_rdata = `ID_LOW_VALUE;
              `REG_NEGOTIATION_ADVERTISEMENT: next_rdata = advert;
              `REG_LINK_PARTNER_ABILITY:      next_rdata = 16'h0000;
              `REG_NEGOTIATION_EXPANSION:     next_rdata = 16'h0000;
              `REG_CONFIG_INFO_IRQ_STATUS:    next_rdata = {control[`CTL_SPEED_POS],
                                                            control[`CTL_DUPLEX_POS],
                                                            14'h0000};
              `REG_IRQ_ENABLE:                next_rdata = irq_en;
              `REG_FAST_TX_CONTROL_STATUS:    next_rdata = fast_ctl;
              `REG_TRANSCEIVER_MODE_CONTROL:  next_rdata = mode_ctl;
              default:                        next_rdata = 16'h0000;
            endcase
          end
        end
      end
      ST_SOFT_RESET: begin
        // Soft reset restores the strap image latched at hardware reset.
        next_count = count + 8'd1;
        {next_control, next_advert} = strap_image(latched);
        next_control[`CTL_SOFT_RESET_POS] = 1'b1;
        next_irq_en   = 16'h0000;
        next_fast_ctl = 16'h0000;
        next_mode_ctl = `MODE_CONTROL_RESET_VALUE;
        if (count == `SOFT_RESET_CYCLES - 8'd1) begin
          next_control[`CTL_SOFT_RESET_POS] = 1'b0;
          next_state = ST_RUN;
        end
      end
      default: next_state = ST_HW_RESET;
    endcase
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      state      <= ST_HW_RESET;
      count      <= 8'd0;
      latched    <= '0;
      control    <= `CTL_RESET_VALUE;
      advert     <= `ADV_RESET_VALUE;
      irq_en     <= 16'h0000;
      fast_ctl   <= 16'h0000;
      mode_ctl   <= `MODE_CONTROL_RESET_VALUE;
      led_pol    <= 5'h00;
      mgmt_ack   <= 1'b0;
      mgmt_rdata <= 16'h0000;
    end else begin
      state      <= next_state;
      count      <= next_count;
      latched    <= next_latched;
      control    <= next_control;
      advert     <= next_advert;
      irq_en     <= next_irq_en;
      fast_ctl   <= next_fast_ctl;
      mode_ctl   <= next_mode_ctl;
      led_pol    <= next_led_pol;
      mgmt_ack   <= next_ack;
      mgmt_rdata <= next_rdata;
    end
  end

  assign phy_address  = latched.address_straps;
  assign ready        = (state == ST_RUN);
  assign loopback_en  = control[`CTL_LOOPBACK_POS];
  assign autoneg_en   = control[`CTL_AUTONEG_POS];
  assign speed_100    = autoneg_en | control[`CTL_SPEED_POS];
  assign full_duplex  = autoneg_en | control[`CTL_DUPLEX_POS];
  assign powerdown    = control[`CTL_POWERDOWN_POS] | pwr_sync;
  assign mii_isolate  = control[`CTL_ISOLATE_POS] | powerdown;
  assign line_tx_oe_n = powerdown;
  // Each LED driver takes the polarity of its own address strap, latched at reset.
  for (genvar gi = 0; gi < 5; gi++) begin : g_led
    assign led_out[gi] = led_status[gi] ^ led_pol[gi];
  end
  assign led_oe_n     = {5{powerdown}};
  assign led_status   = {1'b0, full_duplex, 1'b0, 1'b0, speed_100};
endmodule : phy_strap_config_and_control

// ### verilog/phy_strap_map.svh
// Offsets, field positions, reset values and timing counts of the strap and control block.
// Included by the design module only; the package does not include it.
`ifndef PHY_STRAP_MAP_SVH
`define PHY_STRAP_MAP_SVH
`define REG_TRANSCEIVER_CONTROL        5'h00
`define REG_TRANSCEIVER_STATUS         5'h01
`define REG_PHY_IDENTIFIER_HIGH        5'h02
`define REG_PHY_IDENTIFIER_LOW         5'h03
`define REG_NEGOTIATION_ADVERTISEMENT  5'h04
`define REG_LINK_PARTNER_ABILITY       5'h05
`define REG_NEGOTIATION_EXPANSION      5'h06
`define REG_CONFIG_INFO_IRQ_STATUS     5'h11
`define REG_IRQ_ENABLE                 5'h12
`define REG_FAST_TX_CONTROL_STATUS     5'h13
`define REG_TRANSCEIVER_MODE_CONTROL   5'h14
`define CTL_SOFT_RESET_POS             15
`define CTL_LOOPBACK_POS               14
`define CTL_SPEED_POS                  13
`define CTL_AUTONEG_POS                12
`define CTL_POWERDOWN_POS              11
`define CTL_ISOLATE_POS                10
`define CTL_DUPLEX_POS                 8
`define ADV_FAST_FULL_POS              8
`define ADV_FAST_HALF_POS              7
`define ADV_SLOW_FULL_POS              6
`define ADV_SLOW_HALF_POS              5
`define CTL_RESET_VALUE                16'h3000
`define STATUS_VALUE                   16'h7840
`define ADV_RESET_VALUE                16'h01e1
`define ID_HIGH_VALUE                  16'h1234
`define ID_LOW_VALUE                   16'h5670
`define MODE_CONTROL_RESET_VALUE       16'h0002
`define SOFT_RESET_CYCLES              8'd16
`endif

// ### verilog/phy_strap_pkg.sv
// Types shared by the strap and control block.
// Assumes the constant header is on the include path.
package phy_strap_pkg;
  typedef struct packed {
    logic [4:0] multi_function_straps;
    logic       advertise_strap_a;
    logic       advertise_strap_b;
    logic       duplex_strap;
    logic [4:0] address_straps;
  } strap_bundle_t;

  typedef struct packed {
    logic        valid;
    logic        write;
    logic [4:0]  phy_addr;
    logic [4:0]  reg_addr;
    logic [15:0] wdata;
  } mgmt_req_t;

  typedef enum logic [1:0] {
    ST_HW_RESET   = 2'b00,
    ST_LATCH      = 2'b01,
    ST_RUN        = 2'b10,
    ST_SOFT_RESET = 2'b11
  } cfg_state_t;
endpackage : phy_strap_pkg

// ### verification/phy_strap_monitor.sv
// Port checker for the strap and control block.
// Assumes it is bound to the design top, one clock domain, async active-low reset.
`timescale 1ns/1ns
module phy_strap_monitor
  import phy_strap_pkg::*;
(
  input wire logic       clk_sys,
  input wire logic       nrst,
  input wire mgmt_req_t  mgmt_req,
  input wire logic       mgmt_ack,
  input wire logic [4:0] phy_address,
  input wire logic       ready,
  input wire logic       speed_100,
  input wire logic       autoneg_en,
  input wire logic       full_duplex,
  input wire logic       powerdown,
  input wire logic       mii_isolate,
  input wire logic       line_tx_oe_n,
  input wire logic [4:0] led_status,
  input wire logic [4:0] led_out,
  input wire logic [4:0] led_oe_n
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!nrst);
  logic hit;
  assign hit = ready && mgmt_req.valid && (mgmt_req.phy_addr == phy_address);
  a_ack_follows_hit: assert property (hit |=> mgmt_ack)
    else $error("addressed request not answered");
  a_no_foreign_ack: assert property (mgmt_ack |-> $past(hit))
    else $error("answer without addressed request");
  a_speed_forced: assert property (autoneg_en |-> speed_100)
    else $error("speed not forced under negotiation");
  a_duplex_forced: assert property (autoneg_en |-> full_duplex)
    else $error("duplex not forced under negotiation");
  a_pd_isolates: assert property (powerdown |-> mii_isolate && line_tx_oe_n)
    else $error("power-down does not isolate");
  a_pd_led_float: assert property (powerdown |-> led_oe_n == 5'h1f)
    else $error("LEDs driven in power-down");
  a_led_polarity: assert property (led_out == (led_status ^ phy_address))
    else $error("LED polarity wrong");
  a_soft_reset: assert property (hit && mgmt_req.write && mgmt_req.reg_addr == 5'h00
    && mgmt_req.wdata[15] |=> !ready ##[1:20] ready)
    else $error("soft reset sequence wrong");
  c_write: cover property (hit && mgmt_req.write);
  c_pd: cover property (powerdown);
  c_soft: cover property ($fell(ready));
endmodule : phy_strap_monitor

// ### verification/phy_mgmt_master.sv
// Behavioural management controller issuing one-cycle requests.
// Assumes requests are answered on the taking edge and read back 1 ns after it.
`timescale 1ns/1ns
module phy_mgmt_master
  import phy_strap_pkg::*;
(
  input  wire logic        clk_sys,
  input  wire logic        mgmt_ack,
  input  wire logic [15:0] mgmt_rdata,
  output mgmt_req_t        mgmt_req
);
  initial mgmt_req = '0;
  task automatic xfer(input logic w, input logic [4:0] pa, input logic [4:0] ra,
                      input logic [15:0] wd, output logic ack, output logic [15:0] rd);
    @(posedge clk_sys);
    #1 mgmt_req = '{1'b1, w, pa, ra, wd};
    @(posedge clk_sys);
    // Valid drops and released fields show the inverse, not stale values.
    #1 mgmt_req = ~mgmt_req;
    ack = mgmt_ack;
    rd = mgmt_rdata;
  endtask : xfer
endmodule : phy_mgmt_master

// ### verification/phy_strap_config_and_control_test.sv
// Self-checking bench for the strap and control block.
// Assumes the management master model drives the request port.
`timescale 1ns/1ns
module phy_strap_config_and_control_test;
  import phy_strap_pkg::*;
  logic clk_sys, nrst, pwrdwn_pin, mgmt_ack, ready, loopback_en, speed_100;
  logic autoneg_en, full_duplex, powerdown, mii_isolate, line_tx_oe_n;
  logic [4:0] phy_address, led_status, led_out, led_oe_n;
  logic [15:0] mgmt_rdata;
  strap_bundle_t straps;
  mgmt_req_t mgmt_req;
  int n_errors = 0;
  int checks = 0;
  int cyc = 0;
  phy_strap_config_and_control u_dut(.clk_sys, .nrst, .straps, .pwrdwn_pin, .mgmt_req,
    .mgmt_ack, .mgmt_rdata, .phy_address, .ready, .loopback_en, .speed_100, .autoneg_en,
    .full_duplex, .powerdown, .mii_isolate, .line_tx_oe_n, .led_status, .led_out, .led_oe_n);
  phy_mgmt_master u_mac(.clk_sys, .mgmt_ack, .mgmt_rdata, .mgmt_req);
  initial begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end
  task automatic results();
    $display("checks %0d errors %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : results
  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
    checks++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk
  task automatic wait_ready();
    for (int i = 0; i < 30 && ready !== 1'b1; i++) @(posedge clk_sys) #1;
    chk({15'h0, ready}, 16'h1, "ready");
  endtask : wait_ready
  task automatic boot(input strap_bundle_t s);
    @(posedge clk_sys) #1;
    nrst = 1'b0;
    straps = s;
    repeat (5) @(posedge clk_sys);
    #1 nrst = 1'b1;
    wait_ready();
  endtask : boot
  task automatic acc(input logic w, input logic [4:0] pa, input logic [4:0] ra,
                     input logic [15:0] wd, input logic ea, input logic [15:0] er);
    logic ack;
    logic [15:0] rd;
    u_mac.xfer(w, pa, ra, wd, ack, rd);
    chk({15'h0, ack}, {15'h0, ea}, "ack");
    if (!w && ea) chk(rd, er, "rdata");
  endtask : acc
  task automatic s_adv();
    logic [2:0] code [6] = '{3'b111, 3'b100, 3'b101, 3'b010, 3'b011, 3'b110};
    logic [3:0] bits [6] = '{4'hf, 4'h4, 4'hc, 4'h1, 4'h3, 4'h5};
    for (int i = 0; i < 6; i++) begin
      boot({5'h01, code[i], 5'h05});
      acc(0, 5'h05, 5'h04, 16'h0, 1, {7'h0, bits[i], 5'h01});
      acc(0, 5'h05, 5'h00, 16'h0, 1, 16'h3000);
      chk({11'h0, phy_address}, 16'h0005, "address");
    end
  endtask : s_adv
  task automatic s_noneg();
    boot({5'h00, 3'b111, 5'h00});
    acc(0, 5'h00, 5'h00, 16'h0, 1, 16'h6500);
    acc(0, 5'h00, 5'h04, 16'h0, 1, 16'h01e1);
    chk({15'h0, mii_isolate}, 16'h1, "isolate");
    acc(1, 5'h01, 5'h00, 16'h0, 0, 16'h0);
    straps = '0;
    acc(1, 5'h00, 5'h00, 16'h0000, 1, 16'h0);
    chk({14'h0, speed_100, loopback_en}, 16'h0, "speed");
    acc(1, 5'h00, 5'h00, 16'h8000, 1, 16'h0);
    @(posedge clk_sys) #1;
    wait_ready();
    acc(0, 5'h00, 5'h00, 16'h0, 1, 16'h6500);
  endtask : s_noneg
  task automatic s_map();
    acc(0, 5'h00, 5'h01, 16'h0, 1, 16'h7840);
    acc(1, 5'h00, 5'h01, 16'h0001, 1, 16'h0);
    acc(0, 5'h00, 5'h01, 16'h0, 1, 16'h7840);
    acc(0, 5'h00, 5'h07, 16'h0, 1, 16'h0000);
    acc(0, 5'h00, 5'h14, 16'h0, 1, 16'h0002);
  endtask : s_map
  task automatic s_pd();
    pwrdwn_pin = 1'b1;
    for (int i = 0; i < 8 && powerdown !== 1'b1; i++) @(posedge clk_sys) #1;
    chk({10'h0, led_oe_n, line_tx_oe_n}, 16'h003f, "float");
    pwrdwn_pin = 1'b0;
  endtask : s_pd
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 4000) begin
      n_errors++;
      results();
    end
  end
  initial begin
    nrst = 1'b0;
    pwrdwn_pin = 1'b0;
    straps = '0;
    s_adv();
    s_noneg();
    s_map();
    s_pd();
    results();
  end
endmodule : phy_strap_config_and_control_test
bind phy_strap_config_and_control phy_strap_monitor u_mon(.clk_sys, .nrst, .mgmt_req,
  .mgmt_ack, .phy_address, .ready, .speed_100, .autoneg_en, .full_duplex, .powerdown,
  .mii_isolate, .line_tx_oe_n, .led_status, .led_out, .led_oe_n);
